// File: core/ccm_pkg.sv
/*
 * Shared constants of the clock mode configuration block: register
 * offsets, field positions, reset values, legal code limits and counts.
 * Assumes MSB-0 bit numbering on the register data path (bit 0 is the MSB).
 */
package ccm_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned  ADDR_W                = 17;
  localparam logic [16:0]  CLOCK_CONTROL_OFS     = 17'h10c80;
  localparam logic [16:0]  CLOCK_MODE_STATUS_OFS = 17'h10c88;

  // ****************************************************************
  // Control register fields and reset values
  // ****************************************************************
  localparam int unsigned  CTRL_CLKO_DIS_BIT     = 27;
  localparam int unsigned  CTRL_BAUD_MSB         = 30;
  localparam int unsigned  CTRL_BAUD_LSB         = 31;
  localparam logic         CLKO_DIS_RST          = 1'h0;
  localparam logic [1:0]   BAUD_SEL_RST          = 2'h1;

  typedef enum logic [1:0] {
    CCM_BAUD_DIV4   = 2'h0,
    CCM_BAUD_DIV16  = 2'h1,
    CCM_BAUD_DIV64  = 2'h2,
    CCM_BAUD_DIV256 = 2'h3
  } ccm_baud_sel_t;

  localparam logic [7:0]   BAUD_TERM_DIV4        = 8'h03;
  localparam logic [7:0]   BAUD_TERM_DIV16       = 8'h0f;
  localparam logic [7:0]   BAUD_TERM_DIV64       = 8'h3f;
  localparam logic [7:0]   BAUD_TERM_DIV256      = 8'hff;

  // ****************************************************************
  // Mode status register fields (MSB-0 positions)
  // ****************************************************************
  localparam int unsigned  ST_CORE_PDF_MSB       = 0;
  localparam int unsigned  ST_CORE_PDF_LSB       = 3;
  localparam int unsigned  ST_CORE_MF_MSB        = 4;
  localparam int unsigned  ST_CORE_MF_LSB        = 7;
  localparam int unsigned  ST_BUS_DF_MSB         = 8;
  localparam int unsigned  ST_BUS_DF_LSB         = 11;
  localparam int unsigned  ST_COMM_DF_MSB        = 12;
  localparam int unsigned  ST_COMM_DF_LSB        = 15;
  localparam int unsigned  ST_SYS_PDF_MSB        = 16;
  localparam int unsigned  ST_SYS_PDF_LSB        = 19;
  localparam int unsigned  ST_SYS_MF_MSB         = 20;
  localparam int unsigned  ST_SYS_MF_LSB         = 23;
  localparam int unsigned  ST_DLL_DIS_BIT        = 25;
  localparam int unsigned  ST_CORE_DF_MSB        = 28;
  localparam int unsigned  ST_CORE_DF_LSB        = 31;
  localparam logic [31:0]  STATUS_RST            = 32'h0000_0000;

  // Legal code ranges of each mode field
  localparam logic [3:0]   CORE_PDF_MAX          = 4'h3;
  localparam logic [3:0]   CORE_MF_MIN           = 4'h5;
  localparam logic [3:0]   CORE_MF_MAX           = 4'h7;
  localparam logic [3:0]   BUS_DF_MIN            = 4'h1;
  localparam logic [3:0]   BUS_DF_MAX            = 4'h5;
  localparam logic [3:0]   COMM_DF_MAX           = 4'h2;
  localparam logic [3:0]   SYS_PDF_MAX           = 4'h5;
  localparam logic [3:0]   SYS_MF_MIN            = 4'h5;
  localparam logic [3:0]   SYS_MF_MAX            = 4'hf;
  localparam logic [3:0]   CORE_DF_MAX           = 4'h5;

  // ****************************************************************
  // Counts
  // ****************************************************************
  localparam logic [1:0]   SERIAL_TERM           = 2'h3;
  localparam int unsigned  SERIAL_DIV            = 4;

  typedef enum logic [1:0] {
    CCM_FILL_A = 2'h0,
    CCM_FILL_B = 2'h1,
    CCM_SETTLE = 2'h3,
    CCM_LOCKED = 2'h2
  } ccm_por_state_t;

endpackage : ccm_pkg

// File: core/ccm_mode_decode.sv
/*
 * Maps the six-bit clock mode onto the mode status word.
 * Assumes a combinational use; the caller latches the result.
 */
`timescale 1ns/1ps
`default_nettype none

module ccm_mode_decode (
  input  wire logic [5:0]  mode,
  output logic      [0:31] status_word
);
  import ccm_pkg::*;

  function automatic logic [3:0] clip(input logic [3:0] v, input logic [3:0] hi);
    clip = (v > hi) ? hi : v;
  endfunction : clip

  logic [1:0] hi_pair;

  always_comb begin
    hi_pair     = (mode[4:3] == 2'h3) ? 2'h2 : mode[4:3];
    status_word = STATUS_RST;
    status_word[ST_CORE_PDF_MSB:ST_CORE_PDF_LSB] = {2'h0, mode[1:0]};
    status_word[ST_CORE_MF_MSB:ST_CORE_MF_LSB]   = CORE_MF_MIN + {2'h0, hi_pair};
    status_word[ST_BUS_DF_MSB:ST_BUS_DF_LSB]     = BUS_DF_MIN + {2'h0, mode[5:4]};
    status_word[ST_COMM_DF_MSB:ST_COMM_DF_LSB]   = {2'h0, mode[5], 1'h0};
    status_word[ST_SYS_PDF_MSB:ST_SYS_PDF_LSB]   = clip({1'h0, mode[2:0]}, SYS_PDF_MAX);
    status_word[ST_SYS_MF_MSB:ST_SYS_MF_LSB]     =
      (mode[3:0] > 4'ha) ? SYS_MF_MAX : SYS_MF_MIN + mode[3:0];
    status_word[ST_DLL_DIS_BIT]                  = mode[5] & mode[0];
    status_word[ST_CORE_DF_MSB:ST_CORE_DF_LSB]   = {2'h0, hi_pair};
  end

endmodule : ccm_mode_decode

`default_nettype wire

// File: core/ccm_baud_divider.sv
/*
 * Baud generator clock divider: one-cycle enable every 4, 16, 64 or 256
 * cycles. Assumes the select comes from a register on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module ccm_baud_divider (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic                  restart,
  input  wire ccm_pkg::ccm_baud_sel_t sel,
  output logic                       tick
);
  import ccm_pkg::*;

  function automatic logic [7:0] term_of(input ccm_baud_sel_t s);
    unique case (s)
      CCM_BAUD_DIV4:   term_of = BAUD_TERM_DIV4;
      CCM_BAUD_DIV16:  term_of = BAUD_TERM_DIV16;
      CCM_BAUD_DIV64:  term_of = BAUD_TERM_DIV64;
      CCM_BAUD_DIV256: term_of = BAUD_TERM_DIV256;
    endcase
  endfunction : term_of

  logic [7:0] count;
  logic [7:0] term;

  // A new select is adopted at a period boundary or on restart; only
  // restart cuts a period short, and no period is stretched past its end.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 8'h00;
      term  <= BAUD_TERM_DIV16;
    end else if (restart) begin
      count <= 8'h00;
      term  <= term_of(sel);
    end else if (count == term) begin
      count <= 8'h00;
      term  <= term_of(sel);
    end else begin
      count <= count + 8'h01;
    end
  end

  assign tick = (count == term);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_BAUD_MIN_GAP: assert property (tick && !restart |=> !tick [*3])
    else $error("baud tick period shorter than four cycles");

endmodule : ccm_baud_divider

`default_nettype wire

// File: core/ccm_clock_mode_config.sv
/*
 * Clock mode configuration block: samples the mode pins and the high
 * mode bits once at power-on reset release, holds the mode status
 * register, the clock control register, and derives the serial, baud
 * and external clock enables. Assumes rstn is the internal power-on
 * reset and hard_reset a same-clock level from the reset controller.
 */
`timescale 1ns/1ps
`default_nettype none

module ccm_clock_mode_config (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic                       hard_reset,
  input  wire logic [2:0]                 clock_mode_pins,
  input  wire logic [2:0]                 clock_mode_high_bits,
  input  wire logic [ccm_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic [0:31]                reg_wdata,
  output logic      [0:31]                reg_rdata,
  output logic                            reg_rvalid,
  output logic                            mode_locked,
  output logic      [3:0]                 core_pll_predivider,
  output logic      [3:0]                 core_pll_multiplier,
  output logic      [3:0]                 bus_postdivider,
  output logic      [3:0]                 comm_engine_divider,
  output logic      [3:0]                 system_pll_predivider,
  output logic      [3:0]                 system_pll_multiplier,
  output logic                            delay_loop_disable,
  output logic      [3:0]                 core_clock_divider,
  output logic                            serial_clock_en,
  output logic                            baud_generator_clock,
  output logic                            external_clock_output
);
  import ccm_pkg::*;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic ctrl_sel;
  logic stat_sel;

  assign ctrl_sel = hit(reg_addr, CLOCK_CONTROL_OFS);
  assign stat_sel = hit(reg_addr, CLOCK_MODE_STATUS_OFS);

  // ****************************************************************
  // Mode pin synchroniser
  // ****************************************************************
  // The pins are asynchronous straps; the first stage feeds only the second.
  logic [2:0] pins_meta;
  logic [2:0] pins_sync;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pins_meta <= 3'h0;
      pins_sync <= 3'h0;
    end else begin
      pins_meta <= clock_mode_pins;
      pins_sync <= pins_meta;
    end
  end

  // ****************************************************************
  // Power-on release sequence
  // ****************************************************************
  // Two fill cycles let the synchroniser carry pin values taken after
  // release; the mode is then captured exactly once.
  ccm_por_state_t por_state;
  ccm_por_state_t next_por_state;
  logic           latch_now;

  always_comb begin
    next_por_state = por_state;
    unique case (por_state)
      CCM_FILL_A: next_por_state = CCM_FILL_B;
      CCM_FILL_B: next_por_state = CCM_SETTLE;
      CCM_SETTLE: next_por_state = CCM_LOCKED;
      CCM_LOCKED: next_por_state = CCM_LOCKED;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      por_state <= CCM_FILL_A;
    end else begin
      por_state <= next_por_state;
    end
  end

  assign latch_now = (por_state == CCM_SETTLE);

  // ****************************************************************
  // Mode capture and status register
  // ****************************************************************
  logic [5:0]  mode_now;
  logic [5:0]  mode_value;
  logic [0:31] status_word;
  logic [0:31] status_reg;

  assign mode_now = {clock_mode_high_bits, pins_sync};

  ccm_mode_decode u_decode (
    .mode        (mode_now),
    .status_word (status_word)
  );

  // Neither hard reset nor bus writes reach this register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_value <= 6'h00;
      status_reg <= STATUS_RST;
      mode_locked <= 1'h0;
    end else if (latch_now) begin
      mode_value  <= mode_now;
      status_reg  <= status_word;
      mode_locked <= 1'h1;
    end
  end

  // Mode control signals to the PLLs, delay loop and clock logic
  assign core_pll_predivider   = status_reg[ST_CORE_PDF_MSB:ST_CORE_PDF_LSB];
  assign core_pll_multiplier   = status_reg[ST_CORE_MF_MSB:ST_CORE_MF_LSB];
  assign bus_postdivider       = status_reg[ST_BUS_DF_MSB:ST_BUS_DF_LSB];
  assign comm_engine_divider   = status_reg[ST_COMM_DF_MSB:ST_COMM_DF_LSB];
  assign system_pll_predivider = status_reg[ST_SYS_PDF_MSB:ST_SYS_PDF_LSB];
  assign system_pll_multiplier = status_reg[ST_SYS_MF_MSB:ST_SYS_MF_LSB];
  assign delay_loop_disable    = status_reg[ST_DLL_DIS_BIT];
  assign core_clock_divider    = status_reg[ST_CORE_DF_MSB:ST_CORE_DF_LSB];

  // ****************************************************************
  // Clock control register
  // ****************************************************************
  // Only power-on reset initialises it; reserved bits are not stored, so a
  // careless nonzero write to them has no effect.
  logic          clock_output_disable;
  ccm_baud_sel_t baud_clock_divider;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clock_output_disable <= CLKO_DIS_RST;
      baud_clock_divider   <= ccm_baud_sel_t'(BAUD_SEL_RST);
    end else if (reg_wr && ctrl_sel) begin
      clock_output_disable <= reg_wdata[CTRL_CLKO_DIS_BIT];
      baud_clock_divider   <= ccm_baud_sel_t'(reg_wdata[CTRL_BAUD_MSB:CTRL_BAUD_LSB]);
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  logic [0:31] ctrl_word;

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[CTRL_CLKO_DIS_BIT] = clock_output_disable;
    ctrl_word[CTRL_BAUD_MSB:CTRL_BAUD_LSB] = baud_clock_divider;
  end

  // Unmapped addresses read as zero; every read is answered next cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata  <= 32'h0000_0000;
      reg_rvalid <= 1'h0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        if (ctrl_sel) begin
          reg_rdata <= ctrl_word;
        end else if (stat_sel) begin
          reg_rdata <= status_reg;
        end else begin
          reg_rdata <= 32'h0000_0000;
        end
      end
    end
  end

  // ****************************************************************
  // Derived clock enables
  // ****************************************************************
  // Dividers are held until the mode is locked and restart on hard
  // reset; the registers themselves keep their contents.
  logic       div_hold;
  logic [1:0] serial_count;

  assign div_hold = hard_reset || !mode_locked;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serial_count <= 2'h0;
    end else if (div_hold) begin
      serial_count <= 2'h0;
    end else begin
      serial_count <= serial_count + 2'h1;
    end
  end

  assign serial_clock_en = !div_hold && (serial_count == SERIAL_TERM);

  ccm_baud_divider u_baud (
    .clk     (clk),
    .rstn    (rstn),
    .restart (div_hold),
    .sel     (baud_clock_divider),
    .tick    (baud_generator_clock)
  );

  // External clock output toggles at half rate; while disabled it holds
  // its last level, which users must treat as undefined.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      external_clock_output <= 1'h0;
    end else if (!clock_output_disable && !div_hold) begin
      external_clock_output <= !external_clock_output;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic [0:31] status_ref;
  assign status_ref = status_word;

  AST_MODE_FROZEN: assert property (mode_locked |=> $stable(status_reg) && $stable(mode_value))
    else $error("mode register changed after lock");

  AST_MODE_CAPTURE: assert property (latch_now |=> status_reg == $past(status_ref))
    else $error("mode register did not load configuration");

  AST_MODE_SOURCE: assert property (latch_now |=>
      mode_value == {$past(clock_mode_high_bits), $past(pins_sync)})
    else $error("mode value not formed from pins and high bits");

  AST_LOCK_TIMING: assert property ($rose(por_state == CCM_FILL_B) |-> ##2 mode_locked)
    else $error("mode not locked two cycles after fill");

  // Hard reset restarts the divider, so a period it cuts is not judged.
  AST_SERIAL_DIV4: assert property (disable iff (!rstn || hard_reset)
      serial_clock_en |=> !serial_clock_en [*3] ##1 serial_clock_en)
    else $error("serial clock enable period is not four");

  AST_CTRL_READ: assert property (reg_rd && ctrl_sel |=>
      reg_rvalid && reg_rdata[0:26] == 27'h0 && reg_rdata[28:29] == 2'h0)
    else $error("control register reserved bits read nonzero");

  AST_CLKO_HOLD: assert property (clock_output_disable |=> $stable(external_clock_output))
    else $error("clock output moved while disabled");

  AST_BAUD_WRITE: assert property (reg_wr && ctrl_sel |=>
      baud_clock_divider == $past(reg_wdata[CTRL_BAUD_MSB:CTRL_BAUD_LSB]))
    else $error("baud divider write not stored");

  AST_HARD_KEEP: assert property (hard_reset && !(reg_wr && ctrl_sel) |=>
      $stable(clock_output_disable) && $stable(baud_clock_divider))
    else $error("hard reset altered control register");

  AST_RO_WRITE: assert property (reg_wr && stat_sel |=> $stable(status_reg))
    else $error("write changed mode status register");

  AST_FIELDS_LEGAL: assert property (mode_locked |->
      core_pll_predivider <= CORE_PDF_MAX &&
      core_pll_multiplier inside {[CORE_MF_MIN:CORE_MF_MAX]} &&
      bus_postdivider inside {[BUS_DF_MIN:BUS_DF_MAX]} &&
      comm_engine_divider <= COMM_DF_MAX &&
      system_pll_predivider <= SYS_PDF_MAX &&
      system_pll_multiplier >= SYS_MF_MIN &&
      core_clock_divider <= CORE_DF_MAX)
    else $error("mode field holds an unused code");

  AST_STATUS_READ: assert property (reg_rd && stat_sel && mode_locked |=>
      reg_rdata == status_reg && delay_loop_disable == reg_rdata[ST_DLL_DIS_BIT])
    else $error("mode status read mismatch");

endmodule : ccm_clock_mode_config

`default_nettype wire

// File: tb/test_ccm_clock_mode_config.sv
/*
 * Self-checking testbench of the clock mode configuration block.
 * Assumes ccm_pkg and ccm_clock_mode_config are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none

module test_ccm_clock_mode_config;
  import ccm_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic              clk;
  logic              rstn;
  logic              hard_reset;
  logic [2:0]        clock_mode_pins;
  logic [2:0]        clock_mode_high_bits;
  logic [ADDR_W-1:0] reg_addr;
  logic              reg_wr;
  logic              reg_rd;
  logic [0:31]       reg_wdata;
  logic [0:31]       reg_rdata;
  logic              reg_rvalid;
  logic              mode_locked;
  logic [3:0]        core_pll_predivider;
  logic [3:0]        core_pll_multiplier;
  logic [3:0]        bus_postdivider;
  logic [3:0]        comm_engine_divider;
  logic [3:0]        system_pll_predivider;
  logic [3:0]        system_pll_multiplier;
  logic              delay_loop_disable;
  logic [3:0]        core_clock_divider;
  logic              serial_clock_en;
  logic              baud_generator_clock;
  logic              external_clock_output;
  int                err_total;
  int                samples_checked;
  logic [5:0]        modes [4] = '{6'h2d, 6'h1a, 6'h3f, 6'h00};
  logic [0:31]       rd;
  int                gap;

  ccm_clock_mode_config i_ccm_clock_mode_config (
    .clk                   (clk),
    .rstn                  (rstn),
    .hard_reset            (hard_reset),
    .clock_mode_pins       (clock_mode_pins),
    .clock_mode_high_bits  (clock_mode_high_bits),
    .reg_addr              (reg_addr),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_wdata             (reg_wdata),
    .reg_rdata             (reg_rdata),
    .reg_rvalid            (reg_rvalid),
    .mode_locked           (mode_locked),
    .core_pll_predivider   (core_pll_predivider),
    .core_pll_multiplier   (core_pll_multiplier),
    .bus_postdivider       (bus_postdivider),
    .comm_engine_divider   (comm_engine_divider),
    .system_pll_predivider (system_pll_predivider),
    .system_pll_multiplier (system_pll_multiplier),
    .delay_loop_disable    (delay_loop_disable),
    .core_clock_divider    (core_clock_divider),
    .serial_clock_en       (serial_clock_en),
    .baud_generator_clock  (baud_generator_clock),
    .external_clock_output (external_clock_output)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("Checks made %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic reg_write(input logic [16:0] addr, input logic [0:31] data);
    @(posedge clk);
    #1 reg_wr = 1'h1;
    reg_addr  = addr;
    reg_wdata = data;
    @(posedge clk);
    #1 reg_wr = 1'h0;
  endtask : reg_write

  task automatic reg_read(input logic [16:0] addr, output logic [0:31] data);
    @(posedge clk);
    #1 reg_rd = 1'h1;
    reg_addr = addr;
    @(posedge clk);
    #1 reg_rd = 1'h0;
    check("read valid", {31'h0, reg_rvalid}, 32'h1);
    data = reg_rdata;
  endtask : reg_read

  function automatic logic [0:31] ctrl_word(input logic dis, input logic [1:0] baud);
    logic [0:31] w;
    w        = '0;
    w[27]    = dis;
    w[30:31] = baud;
    return w;
  endfunction : ctrl_word

  // Mode mapping chosen by the design team: high bits on top of the pins
  function automatic logic [0:31] exp_status(input logic [5:0] m);
    logic [0:31] w;
    logic [1:0]  hp;
    w        = '0;
    hp       = (m[4:3] > 2'h2) ? 2'h2 : m[4:3];
    w[0:3]   = {2'h0, m[1:0]};
    w[4:7]   = 4'h5 + {2'h0, hp};
    w[8:11]  = 4'h1 + {2'h0, m[5:4]};
    w[12:15] = {2'h0, m[5], 1'h0};
    w[16:19] = (m[2:0] > 3'h5) ? 4'h5 : {1'h0, m[2:0]};
    w[20:23] = (m[3:0] > 4'ha) ? 4'hf : 4'h5 + m[3:0];
    w[25]    = m[5] & m[0];
    w[28:31] = {2'h0, hp};
    return w;
  endfunction : exp_status

  task automatic check_mode(input logic [5:0] m);
    logic [0:31] w;
    check("mode fields", {core_pll_predivider, core_pll_multiplier, bus_postdivider,
          comm_engine_divider, system_pll_predivider, system_pll_multiplier, 1'h0,
          delay_loop_disable, 2'h0, core_clock_divider}, exp_status(m));
    reg_read(CLOCK_MODE_STATUS_OFS, w);
    check("mode status", w, exp_status(m));
  endtask : check_mode

  task automatic power_on(input logic [5:0] m);
    int n;
    @(posedge clk);
    #1 rstn = 1'h0;
    clock_mode_pins      = m[2:0];
    clock_mode_high_bits = m[5:3];
    repeat (16) @(posedge clk);
    check("locked in reset", {31'h0, mode_locked}, 32'h0);
    #1 rstn = 1'h1;
    n = 0;
    while (mode_locked !== 1'h1 && n < 10) begin
      @(posedge clk);
      #1 n++;
    end
    check("lock edge", n, 3);
  endtask : power_on

  // Skips the first tick, which may still close a period of the old length
  task automatic tick_gap(input logic baud, output int g);
    int n;
    int hits;
    int t1;
    n = 0;
    hits = 0;
    t1 = 0;
    g = 0;
    while (hits < 3 && n < 1200) begin
      @(posedge clk);
      #1 n++;
      if ((baud ? baud_generator_clock : serial_clock_en) === 1'h1) begin
        hits++;
        if (hits == 2) t1 = n;
        if (hits == 3) g = n - t1;
      end
    end
  endtask : tick_gap

  task automatic external_clock_output_flips(input int exp);
    logic prev;
    int   flips;
    flips = 0;
    @(posedge clk);
    #1 prev = external_clock_output;
    repeat (8) begin
      @(posedge clk);
      #1 if (external_clock_output !== prev) flips++;
      prev = external_clock_output;
    end
    check("clock out flips", flips, exp);
  endtask : external_clock_output_flips

  // ****************************************************************
  // Clock, watchdog and tests
  // ****************************************************************
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Whole run needs well under 2000 cycles; ten times that is a hang
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    give_verdict();
  end

  initial begin
    err_total = 0;
    samples_checked = 0;
    rstn = 1'h0;
    hard_reset = 1'h0;
    clock_mode_pins = 3'h0;
    clock_mode_high_bits = 3'h0;
    reg_addr = '0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_wdata = '0;
    foreach (modes[i]) begin
      power_on(modes[i]);
      check_mode(modes[i]);
      reg_read(CLOCK_CONTROL_OFS, rd);
      check("control default", rd, ctrl_word(1'h0, 2'h1));
    end
    // Pins move after lock; status must not follow
    #1 clock_mode_pins = 3'h7;
    clock_mode_high_bits = 3'h7;
    repeat (5) @(posedge clk);
    check_mode(modes[3]);
    reg_write(CLOCK_MODE_STATUS_OFS, 32'hffff_ffff);
    check_mode(modes[3]);
    reg_write(17'h10c84, 32'hffff_ffff);
    reg_read(17'h10c84, rd);
    check("unmapped read", rd, 32'h0);
    tick_gap(1'h0, gap);
    check("serial gap", gap, SERIAL_DIV);
    external_clock_output_flips(8);
    reg_write(CLOCK_CONTROL_OFS, 32'hffff_ffff);
    reg_read(CLOCK_CONTROL_OFS, rd);
    check("control reserved", rd, 32'h0000_0013);
    external_clock_output_flips(0);
    for (int c = 0; c < 4; c++) begin
      reg_write(CLOCK_CONTROL_OFS, ctrl_word(1'h0, c[1:0]));
      reg_read(CLOCK_CONTROL_OFS, rd);
      check("control baud", rd, ctrl_word(1'h0, c[1:0]));
      tick_gap(1'h1, gap);
      check("baud gap", gap, 4 << (2 * c));
      check("still locked", {31'h0, mode_locked}, 32'h1);
    end
    external_clock_output_flips(8);
    reg_write(CLOCK_CONTROL_OFS, ctrl_word(1'h1, 2'h2));
    @(posedge clk);
    #1 hard_reset = 1'h1;
    repeat (3) @(posedge clk);
    #1 hard_reset = 1'h0;
    reg_read(CLOCK_CONTROL_OFS, rd);
    check("control after hard reset", rd, ctrl_word(1'h1, 2'h2));
    check_mode(modes[3]);
    tick_gap(1'h1, gap);
    check("baud gap after hard reset", gap, 64);
    power_on(modes[0]);
    reg_read(CLOCK_CONTROL_OFS, rd);
    check("control after power on", rd, ctrl_word(1'h0, 2'h1));
    check_mode(modes[0]);
    give_verdict();
  end

endmodule : test_ccm_clock_mode_config

`default_nettype wire
